// ---- common/pwrs_defines.vh ----
// Offsets, field positions, reset values and timing counts for the wake/reset block
`ifndef PWRS_DEFINES_VH
`define PWRS_DEFINES_VH
`define PWRS_RSS_OFS 16'h1800
`define PWRS_PTSC_OFS 16'h1804
`define PWRS_OPTIONS_REGISTER_OFS 16'h1808
`define PWRS_PTSC_FLAG 7
`define PWRS_PTSC_CLR 6
`define PWRS_PTSC_CSEL 5
`define PWRS_PTSC_IEN 4
`define PWRS_OPTIONS_REGISTER_WDEN 7
`define PWRS_OPTIONS_REGISTER_SLPEN 5
`define PWRS_OPTIONS_REGISTER_TREN 3
`define PWRS_OPTIONS_REGISTER_TRLV 2
`define PWRS_OPTIONS_REGISTER_RES1 0
`define PWRS_OPTIONS_REGISTER_RST 8'h80
`define PWRS_OPTIONS_REGISTER_WDEN_RST 1'b1
`define PWRS_RSS_PWRON 8'h82
`define PWRS_RSS_NONE 8'h00
`define PWRS_MODE_RUN 3'h0
`define PWRS_MODE_WAIT 3'h1
`define PWRS_MODE_LIGHT 3'h2
`define PWRS_MODE_MID 3'h3
`define PWRS_MODE_DEEP 3'h4
`define PWRS_CAPT_EDGE 2'h2
`endif

// ---- hw/pwrs_top.v ----
// Periodic wakeup timer, thermal restart wakeup and reset source status
//
// The implementer's own choice: the APB register port.
`include "pwrs_defines.vh"
module pwrs_top #(
	parameter AW = 16
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [AW-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire slow_osc,
	input wire fast_osc,
	input wire [2:0] cpu_mode,
	input wire temp_too_cold,
	input wire temp_too_hot,
	input wire sleep_instr_exec,
	input wire halt_instr_exec,
	input wire undef_opcode,
	input wire background_mode_enable,
	input wire cause_power_on,
	input wire cause_low_supply,
	input wire cause_pin,
	input wire cause_watchdog,
	input wire cause_bad_opcode,
	input wire cause_bad_address,
	input wire cause_wake,
	input wire cause_debug_force,
	input wire cause_in_deep_sleep,
	input wire low_supply_reset_enable,
	input wire low_supply_sleep_enable,
	output reg timer_irq,
	output reg timer_wake,
	output reg thermal_wake,
	output reg deep_exit_reset,
	output reg bad_opcode_reset,
	output reg watchdog_restart
);

	// Terminal count for a period code: 2^code ticks, minus one
	function [7:0] pwrs_term;
		input [2:0] code;
		begin
			pwrs_term = (8'h01 << code) - 8'h01;
		end
	endfunction

	// Register map hit test
	function pwrs_hit;
		input [AW-1:0] a;
		input [15:0] ofs;
		begin
			pwrs_hit = (a == ofs[AW-1:0]);
		end
	endfunction

	reg [2:0] slow_sync_r;
	reg [2:0] fast_sync_r;
	reg [1:0] cold_sync_r;
	reg [1:0] hot_sync_r;
	reg cold_prev_r;
	reg [8:0] cause_s1_r;
	reg [8:0] cause_s2_r;
	reg [1:0] capt_cnt_r;
	reg [7:0] rss_r;
	reg flag_r;
	reg csel_r;
	reg ien_r;
	reg [2:0] ival_r;
	reg [7:0] tick_cnt_r;
	reg wden_r;
	reg slpen_r;
	reg wdlock_r;
	reg slplock_r;
	reg tren_r;
	reg trlv_r;
	reg armed_r;
	reg [7:0] rss_nxt;
	reg [31:0] rdata_nxt;
	reg map_ok;
	wire setup;
	wire wr_take;
	wire slow_edge;
	wire fast_edge;
	wire use_fast;
	wire tick;
	wire expire;
	wire flag_clr;
	wire in_sleep;
	wire cold_back;
	wire hot_back;
	wire illegal_op;

	// Oscillator and temperature pins pass two flops before any logic looks at them
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			slow_sync_r <= 3'h0;
			fast_sync_r <= 3'h0;
			cold_sync_r <= 2'h0;
			hot_sync_r <= 2'h0;
			cold_prev_r <= 1'b0;
		end
		else
		begin
			slow_sync_r <= {slow_sync_r[1:0], slow_osc};
			fast_sync_r <= {fast_sync_r[1:0], fast_osc};
			cold_sync_r <= {cold_sync_r[0], temp_too_cold};
			hot_sync_r <= {hot_sync_r[0], temp_too_hot};
			cold_prev_r <= cold_sync_r[1];
		end
	end

	// Edge detect looks only at the second and third stages
	assign slow_edge = slow_sync_r[1] & ~slow_sync_r[2];
	assign fast_edge = fast_sync_r[1] & ~fast_sync_r[2];
	// Fast clock leaves with run mode, so a sleeping part keeps ticking
	assign use_fast = csel_r & (cpu_mode == `PWRS_MODE_RUN);
	assign tick = use_fast ? fast_edge : slow_edge;
	assign expire = tick & (ival_r != 3'h0) & (tick_cnt_r == pwrs_term(ival_r));
	assign in_sleep = (cpu_mode != `PWRS_MODE_RUN);

	// APB phase decode; no wait state, write lands on the pready edge
	assign setup = psel & ~penable & ~pready;
	assign wr_take = psel & penable & pready & pwrite & map_ok;
	assign flag_clr = wr_take & pwrs_hit(paddr, `PWRS_PTSC_OFS) & pwdata[`PWRS_PTSC_CLR];

	// Address decode for the three words
	always @*
	begin
		map_ok = pwrs_hit(paddr, `PWRS_RSS_OFS) | pwrs_hit(paddr, `PWRS_PTSC_OFS)
			| pwrs_hit(paddr, `PWRS_OPTIONS_REGISTER_OFS);
	end

	// Read mux; clear bit and unused bits read zero, except the options reserved bit
	always @*
	begin
		rdata_nxt = 32'h0;
		if (pwrs_hit(paddr, `PWRS_RSS_OFS))
		begin
			// Bit 0 is forced low here so a stray capture can never show
			rdata_nxt[7:1] = rss_r[7:1];
			rdata_nxt[0] = 1'b0;
		end
		else if (pwrs_hit(paddr, `PWRS_PTSC_OFS))
		begin
			rdata_nxt[`PWRS_PTSC_FLAG] = flag_r;
			rdata_nxt[`PWRS_PTSC_CLR] = 1'b0;
			rdata_nxt[`PWRS_PTSC_CSEL] = csel_r;
			rdata_nxt[`PWRS_PTSC_IEN] = ien_r;
			rdata_nxt[2:0] = ival_r;
		end
		else if (pwrs_hit(paddr, `PWRS_OPTIONS_REGISTER_OFS))
		begin
			rdata_nxt[`PWRS_OPTIONS_REGISTER_WDEN] = wden_r;
			rdata_nxt[`PWRS_OPTIONS_REGISTER_SLPEN] = slpen_r;
			rdata_nxt[`PWRS_OPTIONS_REGISTER_TREN] = tren_r;
			rdata_nxt[`PWRS_OPTIONS_REGISTER_TRLV] = trlv_r;
			// Reserved bit is tied high
			rdata_nxt[`PWRS_OPTIONS_REGISTER_RES1] = 1'b1;
		end
	end

	// Bus answer flops
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= setup;
			// A miss answers with an error; the write strobe already excludes it
			pslverr <= setup & ~map_ok;
			if (setup)
				prdata <= rdata_nxt;
		end
	end

	// Timer control and flag; a set in the clear cycle wins
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flag_r <= 1'b0;
			csel_r <= 1'b0;
			ien_r <= 1'b0;
			ival_r <= 3'h0;
		end
		else
		begin
			if (expire)
				flag_r <= 1'b1;
			else if (flag_clr)
				flag_r <= 1'b0;
			if (wr_take && pwrs_hit(paddr, `PWRS_PTSC_OFS))
			begin
				csel_r <= pwdata[`PWRS_PTSC_CSEL];
				ien_r <= pwdata[`PWRS_PTSC_IEN];
				ival_r <= pwdata[2:0];
			end
		end
	end

	// Tick counter; restarts when the interval is rewritten
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick_cnt_r <= 8'h0;
		else if (ival_r == 3'h0 || (wr_take && pwrs_hit(paddr, `PWRS_PTSC_OFS)))
			tick_cnt_r <= 8'h0;
		else if (expire)
			tick_cnt_r <= 8'h0;
		else if (tick)
			tick_cnt_r <= tick_cnt_r + 8'h01;
	end

	// System option bits; watchdog and sleep enables take only one write
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wden_r <= `PWRS_OPTIONS_REGISTER_WDEN_RST;
			slpen_r <= 1'b0;
			wdlock_r <= 1'b0;
			slplock_r <= 1'b0;
			tren_r <= 1'b0;
			trlv_r <= 1'b0;
		end
		else if (wr_take && pwrs_hit(paddr, `PWRS_OPTIONS_REGISTER_OFS))
		begin
			// The locks close on the first write, whatever its data
			wdlock_r <= 1'b1;
			slplock_r <= 1'b1;
			if (!wdlock_r)
				wden_r <= pwdata[`PWRS_OPTIONS_REGISTER_WDEN];
			if (!slplock_r)
				slpen_r <= pwdata[`PWRS_OPTIONS_REGISTER_SLPEN];
			tren_r <= pwdata[`PWRS_OPTIONS_REGISTER_TREN];
			trlv_r <= pwdata[`PWRS_OPTIONS_REGISTER_TRLV];
		end
	end

	// Detector leaves the out-of-range zone: falling edge of its level
	assign cold_back = cold_prev_r & ~cold_sync_r[1];
	assign hot_back = hot_sync_r[1] == 1'b0 && armed_r;
	// Sleep or halt is illegal while its enable is off
	assign illegal_op = undef_opcode | (sleep_instr_exec & ~slpen_r)
		| (halt_instr_exec & ~background_mode_enable);

	// Hot level seen last cycle in deep sleep, so a cool part never fires
	// Tracking the level rather than latching it keeps the wake a single pulse
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			armed_r <= 1'b0;
		else if (cpu_mode != `PWRS_MODE_DEEP)
			armed_r <= 1'b0;
		else
			armed_r <= hot_sync_r[1];
	end

	// Event outputs, all registered
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer_irq <= 1'b0;
			timer_wake <= 1'b0;
			thermal_wake <= 1'b0;
			deep_exit_reset <= 1'b0;
			bad_opcode_reset <= 1'b0;
			watchdog_restart <= 1'b0;
		end
		else
		begin
			timer_irq <= flag_r & ien_r & ~flag_clr;
			timer_wake <= expire & in_sleep;
			thermal_wake <= tren_r & (cpu_mode == `PWRS_MODE_DEEP)
				& (trlv_r ? hot_back : cold_back);
			// A thermal wake from deep sleep resets the part one cycle after the wake
			deep_exit_reset <= thermal_wake;
			bad_opcode_reset <= illegal_op;
			watchdog_restart <= wr_take & pwrs_hit(paddr, `PWRS_RSS_OFS);
		end
	end

	// Reset causes are held by the reset controller across the release
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cause_s1_r <= 9'h0;
			cause_s2_r <= 9'h0;
		end
		else
		begin
			cause_s1_r <= {cause_in_deep_sleep, cause_debug_force, cause_wake,
				cause_bad_address, cause_bad_opcode, cause_watchdog, cause_pin,
				cause_low_supply, cause_power_on};
			cause_s2_r <= cause_s1_r;
		end
	end

	// Status pattern from the synchronised causes
	always @*
	begin
		rss_nxt = `PWRS_RSS_NONE;
		if (cause_s2_r[7])
			rss_nxt = `PWRS_RSS_NONE;
		else if (cause_s2_r[0])
			rss_nxt = `PWRS_RSS_PWRON;
		else if (cause_s2_r[1] && low_supply_reset_enable && low_supply_sleep_enable)
			rss_nxt = `PWRS_RSS_PWRON;
		else
		begin
			// Bits 7, 1 and 0 stay clear for every other cause
			rss_nxt[6] = cause_s2_r[2] & ~cause_s2_r[8];
			rss_nxt[5] = cause_s2_r[3] & wden_r;
			rss_nxt[4] = cause_s2_r[4];
			rss_nxt[3] = cause_s2_r[5];
			rss_nxt[2] = cause_s2_r[6] & ~cause_s2_r[8];
		end
	end

	// Capture once, on the third edge after release; then read-only until next reset
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			capt_cnt_r <= 2'h0;
			rss_r <= `PWRS_RSS_NONE;
		end
		else if (capt_cnt_r != 2'h3)
		begin
			capt_cnt_r <= capt_cnt_r + 2'h1;
			if (capt_cnt_r == `PWRS_CAPT_EDGE)
				rss_r <= rss_nxt;
		end
	end

endmodule

// ---- verif/pwrs_top_asserts.sv ----
// Port-level assertions and covers for the wake and reset status block
`include "pwrs_defines.vh"
module pwrs_top_chk #(
	parameter AW = 16
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [AW-1:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire [2:0] cpu_mode,
	input wire timer_irq,
	input wire timer_wake,
	input wire thermal_wake,
	input wire deep_exit_reset,
	input wire watchdog_restart
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Completed read; prdata is only meaningful in this cycle
	wire rd_end = psel && penable && pready && !pwrite;
	wire wr_end = psel && penable && pready && pwrite;
	rsv_zero_a: assert property (rd_end && paddr == `PWRS_RSS_OFS |-> !prdata[0])
		else $error("status bit 0 reads one");
	ack_zero_a: assert property (rd_end && paddr == `PWRS_PTSC_OFS |-> !prdata[6])
		else $error("flag clear bit reads one");
	irq_gate_a: assert property (rd_end && paddr == `PWRS_PTSC_OFS && !prdata[4] |-> !timer_irq)
		else $error("interrupt while disabled");
	wd_restart_a: assert property (wr_end && paddr == `PWRS_RSS_OFS |-> ##[1:2] watchdog_restart)
		else $error("no watchdog restart");
	deep_exit_a: assert property (thermal_wake |=> deep_exit_reset)
		else $error("no reset after thermal wake");
	exit_cause_a: assert property ($rose(deep_exit_reset) |-> $past(thermal_wake))
		else $error("deep exit without wake");
	therm_mode_a: assert property (thermal_wake |-> $past(cpu_mode) == `PWRS_MODE_DEEP)
		else $error("thermal wake outside deep sleep");
	wake_mode_a: assert property (timer_wake |-> $past(cpu_mode) != `PWRS_MODE_RUN)
		else $error("timer wake in run mode");
	cover property (thermal_wake);
	cover property (timer_wake);
	cover property ($rose(timer_irq));
endmodule
bind pwrs_top pwrs_top_chk #(.AW(AW)) u_chk (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata),
	.pready(pready),
	.cpu_mode(cpu_mode),
	.timer_irq(timer_irq),
	.timer_wake(timer_wake),
	.thermal_wake(thermal_wake),
	.deep_exit_reset(deep_exit_reset),
	.watchdog_restart(watchdog_restart)
);

// ---- verif/pwrs_top_tb_top.sv ----
// Self-checking bench for the wake and reset status block
`include "pwrs_defines.vh"
module pwrs_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [15:0] paddr = 16'h0;
	logic [31:0] pwdata = 32'h0, seed = 32'h9eeb, rd;
	logic slow_osc = 0, fast_osc = 0, temp_too_cold = 0, temp_too_hot = 0;
	logic [2:0] cpu_mode = 3'h0;
	logic [1:0] oc = 2'h0;
	logic sleep_instr_exec = 0, halt_instr_exec = 0, undef_opcode = 0;
	logic background_mode_enable = 0, cause_power_on = 0, cause_low_supply = 0;
	logic cause_pin = 0, cause_watchdog = 0, cause_bad_opcode = 0, cause_bad_address = 0;
	logic cause_wake = 0, cause_debug_force = 0, cause_in_deep_sleep = 0;
	logic low_supply_reset_enable = 0, low_supply_sleep_enable = 0;
	logic [7:0] last;
	logic wd;
	wire [31:0] prdata;
	wire pready, pslverr, timer_irq, timer_wake, thermal_wake;
	wire deep_exit_reset, bad_opcode_reset, watchdog_restart;
	int error_cnt = 0, checked = 0, cnt;
	pwrs_top u_dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.slow_osc(slow_osc),
		.fast_osc(fast_osc),
		.cpu_mode(cpu_mode),
		.temp_too_cold(temp_too_cold),
		.temp_too_hot(temp_too_hot),
		.sleep_instr_exec(sleep_instr_exec),
		.halt_instr_exec(halt_instr_exec),
		.undef_opcode(undef_opcode),
		.background_mode_enable(background_mode_enable),
		.cause_power_on(cause_power_on),
		.cause_low_supply(cause_low_supply),
		.cause_pin(cause_pin),
		.cause_watchdog(cause_watchdog),
		.cause_bad_opcode(cause_bad_opcode),
		.cause_bad_address(cause_bad_address),
		.cause_wake(cause_wake),
		.cause_debug_force(cause_debug_force),
		.cause_in_deep_sleep(cause_in_deep_sleep),
		.low_supply_reset_enable(low_supply_reset_enable),
		.low_supply_sleep_enable(low_supply_sleep_enable),
		.timer_irq(timer_irq),
		.timer_wake(timer_wake),
		.thermal_wake(thermal_wake),
		.deep_exit_reset(deep_exit_reset),
		.bad_opcode_reset(bad_opcode_reset),
		.watchdog_restart(watchdog_restart)
	);
	// Bus clock
	initial forever #12.5 pclk = ~pclk;
	// Oscillators: slow runs at a quarter of pclk to keep the long periods short
	always @(posedge pclk)
	begin
		oc <= oc + 2'h1;
		fast_osc <= ~fast_osc;
		if (oc[0])
			slow_osc <= ~slow_osc;
	end
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Cause bits: pwron, lowsup, pin, wdog, opcode, addr, wake, debug, deep
	function logic [7:0] exp_rss(input logic [8:0] c, input logic en);
		if (c[1])
			return 8'h00;
		if (c[8] || (c[7] && en))
			return `PWRS_RSS_PWRON;
		return {1'h0, c[6] & ~c[0], c[5:3], c[2] & ~c[0], 2'h0};
	endfunction
	task summarize();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Entered just after a rising edge; pready is sampled at rising edges only
	task apb(input logic w, input logic [15:0] a, input logic [7:0] d);
		int n;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (!pready && n < 50);
		// Answer taken at the edge that sees pready high, then the request is released
		rd = prdata;
		err = pslverr;
		error_cnt += !pready;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
		// Restart pulse launched by the access edge is sampled here
		wd = watchdog_restart;
	endtask
	task rdchk(input logic [15:0] a, input logic [7:0] e);
		apb(1'h0, a, 8'h00);
		chk(rd[7:0], e);
	endtask
	// Causes stay up well past release, as the reset controller holds them
	task rst(input logic [8:0] c, input logic [1:0] en);
		{cause_power_on, cause_low_supply, cause_pin, cause_watchdog, cause_bad_opcode,
			cause_bad_address, cause_wake, cause_debug_force, cause_in_deep_sleep} <= c;
		{low_supply_reset_enable, low_supply_sleep_enable} <= en;
		presetn <= 1'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		repeat (4) @(posedge pclk);
		last = exp_rss(c, &en);
		rdchk(`PWRS_RSS_OFS, last);
	endtask
	// Main sequence
	initial
	begin
		@(posedge pclk);
		rst(9'h100, 2'h0);
		rst(9'h080, 2'h3);
		rst(9'h0ff, 2'h3);
		rst(9'h07d, 2'h0);
		repeat (6)
		begin
			rd = xs();
			rst({1'h0, rd[7:0]}, rd[9:8]);
		end
		rst(9'h078, 2'h1);
		rdchk(`PWRS_OPTIONS_REGISTER_OFS, 8'h81);
		// Bad opcode, disabled sleep, disabled halt, then a legal halt
		for (int k = 0; k < 4; k++)
		begin
			undef_opcode <= (k == 0);
			sleep_instr_exec <= (k == 1);
			halt_instr_exec <= (k >= 2);
			background_mode_enable <= (k == 3);
			@(posedge pclk);
			{undef_opcode, sleep_instr_exec, halt_instr_exec} <= 3'h0;
			@(negedge pclk);
			chk({7'h0, bad_opcode_reset}, {7'h0, k < 3});
			@(posedge pclk);
		end
		apb(1'h1, `PWRS_RSS_OFS, 8'hff);
		chk({7'h0, wd}, 8'h01);
		rdchk(`PWRS_RSS_OFS, last);
		chk({7'h0, wd}, 8'h00);
		apb(1'h0, 16'h1810, 8'h00);
		chk({7'h0, err}, 8'h01);
		for (int n = 1; n < 8; n++)
		begin
			apb(1'h1, `PWRS_PTSC_OFS, 8'h40);
			apb(1'h1, `PWRS_PTSC_OFS, 8'h10 | n[7:0]);
			cnt = 0;
			while (!timer_irq && cnt < 600)
			begin
				@(negedge pclk);
				cnt++;
			end
			chk({7'h0, cnt >= (1 << n) * 4 - 2 && cnt <= (1 << n) * 4 + 1}, 8'h01);
			@(posedge pclk);
			rdchk(`PWRS_PTSC_OFS, 8'h90 | n[7:0]);
		end
		// Fast clock in run mode: ticks at half the slow spacing
		apb(1'h1, `PWRS_PTSC_OFS, 8'h40);
		apb(1'h1, `PWRS_PTSC_OFS, 8'h31);
		cnt = 0;
		while (!timer_irq && cnt < 600)
		begin
			@(negedge pclk);
			cnt++;
		end
		chk({7'h0, cnt >= 4 && cnt <= 5}, 8'h01);
		@(posedge pclk);
		rdchk(`PWRS_PTSC_OFS, 8'hb1);
		apb(1'h1, `PWRS_PTSC_OFS, 8'h40);
		rdchk(`PWRS_PTSC_OFS, 8'h00);
		chk({7'h0, timer_irq}, 8'h00);
		apb(1'h1, `PWRS_PTSC_OFS, 8'h01);
		cpu_mode <= `PWRS_MODE_DEEP;
		// Sleeping part wakes on expiry; flag set but interrupt stays off
		cnt = 0;
		while (!timer_wake && cnt < 30)
		begin
			@(negedge pclk);
			cnt++;
		end
		chk({7'h0, timer_wake}, 8'h01);
		@(negedge pclk);
		chk({7'h0, timer_irq}, 8'h00);
		@(posedge pclk);
		for (int l = 0; l < 2; l++)
		begin
			apb(1'h1, `PWRS_OPTIONS_REGISTER_OFS, 8'h08 | {5'h0, l[0], 2'h0});
			rdchk(`PWRS_OPTIONS_REGISTER_OFS, 8'h09 | {5'h0, l[0], 2'h0});
			temp_too_hot <= l[0];
			temp_too_cold <= ~l[0];
			repeat (8) @(posedge pclk);
			temp_too_hot <= 1'h0;
			temp_too_cold <= 1'h0;
			cnt = 0;
			while (!thermal_wake && cnt < 30)
			begin
				@(negedge pclk);
				cnt++;
			end
			chk({7'h0, thermal_wake}, 8'h01);
			@(negedge pclk);
			chk({7'h0, deep_exit_reset}, 8'h01);
			chk({7'h0, thermal_wake}, 8'h00);
			@(posedge pclk);
		end
		cpu_mode <= `PWRS_MODE_RUN;
		apb(1'h1, `PWRS_PTSC_OFS, 8'h40);
		summarize();
	end
	// Hang guard, well beyond the longest expected run
	initial
	begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		summarize();
	end
endmodule
